// *** dasr_pkg.sv ***
`default_nettype none
package dasr_pkg;
  localparam int SAMPLE_W = 12;
  localparam int LEAD_W = 4;
  localparam int FRAME_BITS = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int WORD_W = 2 * SAMPLE_W;
  localparam int BIT_CNT_W = 4;
  // Bits still to send after the first one, counted on serial clock falls
  localparam logic [BIT_CNT_W-1:0] BITS_AFTER_FIRST = 4'hF;
  localparam logic [BIT_CNT_W-1:0] LAST_LEAD_LEFT = 4'hC;
  // Fastest sample pair rate: one pair per microsecond
  localparam int SAMPLE_PERIOD_NS = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PACE_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PACE_W = 7;
  localparam logic [PACE_W-1:0] PACE_RELOAD = 7'(PACE_CYC - 1);
  localparam logic [PACE_W-1:0] PACE_ZERO = 7'h00;
  localparam logic [2:0] SYNC_IDLE = 3'h7;
  typedef enum logic [0:0] {
    DASR_IDLE = 1'b0,
    DASR_SHIFT = 1'b1
  } dasr_state_t;
endpackage : dasr_pkg
`default_nettype wire

// *** dasr_fifo_if.sv ***
`default_nettype none
interface dasr_fifo_if #(parameter int WIDTH = 24);
  logic [WIDTH-1:0] wdata;
  logic wvalid;
  logic wready;
  logic [WIDTH-1:0] rdata;
  logic rvalid;
  logic rready;
  modport fifo (input wdata, input wvalid, output wready,
                output rdata, output rvalid, input rready);
  modport user (output wdata, output wvalid, input wready,
                input rdata, input rvalid, output rready);
endinterface : dasr_fifo_if
`default_nettype wire

// *** dasr_fifo.sv ***
`default_nettype none
module dasr_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  dasr_fifo_if.fifo port
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
  logic [AW:0] count, next_count;
  logic not_full, next_not_full;
  logic push, pop;

  // Ready is a flop so that full is exact and needs no comparator at the port
  always_comb begin
    push = port.wvalid && not_full;
    pop = port.rready && (count != '0);
    next_wptr = push ? wptr + 1'b1 : wptr;
    next_rptr = pop ? rptr + 1'b1 : rptr;
    next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);
    next_not_full = next_count != DEPTH_C;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      not_full <= 1'b1;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
      not_full <= next_not_full;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wptr] <= port.wdata;
    end
  end

  assign port.wready = not_full;
  assign port.rvalid = count != '0;
  assign port.rdata = mem[rptr];

  a_fifo_no_over: assert property (@(posedge core_clk) disable iff (sys_rst)
    count == DEPTH_C |-> !port.wready)
    else $error("fifo full but ready");
  a_fifo_count_step: assert property (@(posedge core_clk)
    disable iff (sys_rst)
    push && !pop |=> count == $past(count) + 1'b1)
    else $error("fifo count not advanced on push");
endmodule : dasr_fifo
`default_nettype wire

// *** dasr_readout.sv ***
//----------------------------------------------------------------------
// Contract
// - Two serial data lines, one per channel, outputs only.
// - Frame is 16 serial clocks: four zeros, then twelve result bits.
// - Result bits leave most significant first, least significant last.
// - First leading zero appears on chip select fall, before any clock.
// - Each later bit is updated on a serial clock falling edge.
// - Both channels sampled together, up to one million pairs per second.
//----------------------------------------------------------------------
`default_nettype none
module dasr_readout #(
  parameter int SAMPLE_W = dasr_pkg::SAMPLE_W,
  parameter int FIFO_DEPTH = dasr_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic chip_select_n_pin,
  input wire logic serial_clock_pin,
  input wire logic [SAMPLE_W-1:0] channel_one_analog_in,
  input wire logic [SAMPLE_W-1:0] channel_two_analog_in,
  input wire logic sample_valid,
  output logic sample_ready,
  output logic channel_one_serial_out,
  output logic channel_two_serial_out,
  output logic frame_underrun
);
  localparam int WORD_W = 2 * SAMPLE_W;
  localparam int SH_W = dasr_pkg::FRAME_BITS;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  //--------------------------------------------------------------------
  // Pin synchronisers
  //--------------------------------------------------------------------
  // Three stages each; the filtered level moves only when stages two and
  // three agree, so a single-cycle glitch on a pin is never taken.
  logic [2:0] cs_sync, sck_sync, next_cs_sync, next_sck_sync;
  logic cs_level, sck_level, next_cs_level, next_sck_level;
  logic cs_fall, cs_rise, sck_fall;

  always_comb begin
    next_cs_sync = {cs_sync[1:0], chip_select_n_pin};
    next_sck_sync = {sck_sync[1:0], serial_clock_pin};
    next_cs_level = (cs_sync[1] == cs_sync[2]) ? cs_sync[2] : cs_level;
    next_sck_level = (sck_sync[1] == sck_sync[2]) ? sck_sync[2] : sck_level;
    cs_fall = cs_level && !next_cs_level;
    cs_rise = !cs_level && next_cs_level;
    sck_fall = sck_level && !next_sck_level;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cs_sync <= dasr_pkg::SYNC_IDLE;
      sck_sync <= dasr_pkg::SYNC_IDLE;
      cs_level <= 1'b1;
      sck_level <= 1'b1;
    end else begin
      cs_sync <= next_cs_sync;
      sck_sync <= next_sck_sync;
      cs_level <= next_cs_level;
      sck_level <= next_sck_level;
    end
  end

  //--------------------------------------------------------------------
  // Sample intake and pacing
  //--------------------------------------------------------------------
  dasr_fifo_if #(.WIDTH(WORD_W)) fifo_bus ();

  dasr_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .port(fifo_bus.fifo)
  );

  // A holding register keeps sample_ready a flop; the pacing counter caps
  // the pair rate so the host never sees more than the converter's speed.
  logic hold_full, next_hold_full, next_ready, take, push;
  logic [WORD_W-1:0] hold_data, next_hold_data;
  logic [dasr_pkg::PACE_W-1:0] pace, next_pace;

  always_comb begin
    take = sample_valid && sample_ready;
    push = hold_full && fifo_bus.wready;
    next_hold_full = take || (hold_full && !push);
    next_hold_data = take ? {channel_two_analog_in, channel_one_analog_in}
                          : hold_data;
    if (take) begin
      next_pace = dasr_pkg::PACE_RELOAD;
    end else if (pace != dasr_pkg::PACE_ZERO) begin
      next_pace = pace - 1'b1;
    end else begin
      next_pace = pace;
    end
    next_ready = !next_hold_full && (next_pace == dasr_pkg::PACE_ZERO);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hold_full <= 1'b0;
      hold_data <= '0;
      pace <= dasr_pkg::PACE_ZERO;
      sample_ready <= 1'b0;
    end else begin
      hold_full <= next_hold_full;
      hold_data <= next_hold_data;
      pace <= next_pace;
      sample_ready <= next_ready;
    end
  end

  assign fifo_bus.wdata = hold_data;
  assign fifo_bus.wvalid = hold_full;

  //--------------------------------------------------------------------
  // Frame shifter
  //--------------------------------------------------------------------
  dasr_pkg::dasr_state_t state, next_state;
  logic [SH_W-1:0] shift_one, shift_two, next_shift_one, next_shift_two;
  logic [dasr_pkg::BIT_CNT_W-1:0] bits_left, next_bits_left;
  logic next_out_one, next_out_two, next_underrun, pop;

  always_comb begin
    next_state = state;
    next_shift_one = shift_one;
    next_shift_two = shift_two;
    next_bits_left = bits_left;
    next_out_one = channel_one_serial_out;
    next_out_two = channel_two_serial_out;
    next_underrun = 1'b0;
    pop = 1'b0;
    case (state)
      dasr_pkg::DASR_IDLE: begin
        next_out_one = 1'b0;
        next_out_two = 1'b0;
        if (cs_fall) begin
          // An empty queue sends an all-zero frame and flags it
          pop = fifo_bus.rvalid;
          next_underrun = !fifo_bus.rvalid;
          next_shift_one = {{dasr_pkg::LEAD_W{1'b0}},
            fifo_bus.rvalid ? fifo_bus.rdata[SAMPLE_W-1:0]
                            : {SAMPLE_W{1'b0}}};
          next_shift_two = {{dasr_pkg::LEAD_W{1'b0}},
            fifo_bus.rvalid ? fifo_bus.rdata[WORD_W-1:SAMPLE_W]
                            : {SAMPLE_W{1'b0}}};
          next_out_one = next_shift_one[SH_W-1];
          next_out_two = next_shift_two[SH_W-1];
          next_bits_left = dasr_pkg::BITS_AFTER_FIRST;
          next_state = dasr_pkg::DASR_SHIFT;
        end
      end
      dasr_pkg::DASR_SHIFT: begin
        if (cs_rise) begin
          next_state = dasr_pkg::DASR_IDLE;
          next_out_one = 1'b0;
          next_out_two = 1'b0;
        end else if (sck_fall) begin
          next_shift_one = {shift_one[SH_W-2:0], 1'b0};
          next_shift_two = {shift_two[SH_W-2:0], 1'b0};
          next_out_one = shift_one[SH_W-2];
          next_out_two = shift_two[SH_W-2];
          // Extra clocks past the sixteenth read zero, not stale data
          if (bits_left != '0) begin
            next_bits_left = bits_left - 1'b1;
          end
        end
      end
      default: begin
        next_state = dasr_pkg::DASR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= dasr_pkg::DASR_IDLE;
      shift_one <= '0;
      shift_two <= '0;
      bits_left <= '0;
      channel_one_serial_out <= 1'b0;
      channel_two_serial_out <= 1'b0;
      frame_underrun <= 1'b0;
    end else begin
      state <= next_state;
      shift_one <= next_shift_one;
      shift_two <= next_shift_two;
      bits_left <= next_bits_left;
      channel_one_serial_out <= next_out_one;
      channel_two_serial_out <= next_out_two;
      frame_underrun <= next_underrun;
    end
  end

  assign fifo_bus.rready = pop;

  //--------------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------------
  a_first_lead_zero: assert property (
    state == dasr_pkg::DASR_IDLE && cs_fall |=>
      state == dasr_pkg::DASR_SHIFT && !channel_one_serial_out
      && !channel_two_serial_out && bits_left == dasr_pkg::BITS_AFTER_FIRST)
    else $error("first zero not driven on select fall");
  a_lead_zeros_held: assert property (
    state == dasr_pkg::DASR_SHIFT && bits_left >= dasr_pkg::LAST_LEAD_LEFT
      |-> !channel_one_serial_out && !channel_two_serial_out)
    else $error("leading bit not zero");
  a_msb_first_shift: assert property (
    state == dasr_pkg::DASR_SHIFT && !cs_rise && sck_fall |=>
      channel_one_serial_out == $past(shift_one[SH_W-2])
      && channel_two_serial_out == $past(shift_two[SH_W-2]))
    else $error("bit order wrong");
  a_update_on_fall: assert property (
    state == dasr_pkg::DASR_SHIFT && !sck_fall && !cs_rise |=>
      $stable(channel_one_serial_out) && $stable(channel_two_serial_out))
    else $error("data changed without clock fall");
  a_bit_count_step: assert property (
    state == dasr_pkg::DASR_SHIFT && sck_fall && !cs_rise
      && bits_left != '0 |=> bits_left == $past(bits_left) - 1'b1)
    else $error("bit counter not stepping");
  a_pair_loaded: assert property (
    state == dasr_pkg::DASR_IDLE && cs_fall && fifo_bus.rvalid |=>
      shift_one[SAMPLE_W-1:0] == $past(fifo_bus.rdata[SAMPLE_W-1:0])
      && shift_two[SAMPLE_W-1:0] == $past(fifo_bus.rdata[WORD_W-1:SAMPLE_W]))
    else $error("channel pair not loaded together");
  a_pace_limit: assert property (
    take |=> !sample_ready [*8])
    else $error("sample accepted too soon");
  a_idle_quiet: assert property (
    state == dasr_pkg::DASR_IDLE && !cs_fall |=>
      !channel_one_serial_out && !channel_two_serial_out)
    else $error("data line driven outside frame");
endmodule : dasr_readout
`default_nettype wire

// *** dasr_host.sv ***
`default_nettype none
// ----------------------------------------------------------------------
// Host board model: drives select and serial clock, captures both lines
// ----------------------------------------------------------------------
module dasr_host (
  output logic cs_n,
  output logic sck,
  input wire logic out_one,
  input wire logic out_two
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n = 1'b1;
    sck = 1'b1;
  end
  // Clock idles high and stands still between frames
  task automatic frame(output logic [15:0] w1, output logic [15:0] w2);
    w1 = 16'h0000;
    w2 = 16'h0000;
    #3 cs_n = 1'b0;
    #57;
    // Capture late in the high phase, as far from the previous fall as possible
    for (int i = 0; i < 16; i++) begin
      w1 = {w1[14:0], out_one};
      w2 = {w2[14:0], out_two};
      sck = 1'b0;
      #40 sck = 1'b1;
      #40;
    end
    cs_n = 1'b1;
    #80;
  endtask : frame
endmodule : dasr_host
`default_nettype wire

// *** dual_adc_serial_readout_test.sv ***
`default_nettype none
module dual_adc_serial_readout_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk;
  logic sys_rst;
  logic sample_valid;
  logic [11:0] ch1;
  logic [11:0] ch2;
  wire cs_n;
  wire sck;
  wire rdy;
  wire out_one;
  wire out_two;
  wire under;
  int error_cnt;
  int checks;
  int under_cnt;

  dasr_readout dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .chip_select_n_pin(cs_n), .serial_clock_pin(sck),
    .channel_one_analog_in(ch1), .channel_two_analog_in(ch2),
    .sample_valid(sample_valid), .sample_ready(rdy),
    .channel_one_serial_out(out_one), .channel_two_serial_out(out_two),
    .frame_underrun(under));
  dasr_host host (.cs_n(cs_n), .sck(sck), .out_one(out_one),
    .out_two(out_two));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (under === 1'b1) under_cnt++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------------
  // Shared drivers
  // ----------------------------------------------------------------------
  task automatic push(input logic [11:0] a, input logic [11:0] b);
    int n;
    n = 0;
    // Step off the edge so a ready that falls on it is not read stale
    #1;
    while (rdy !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      #1 n++;
    end
    check({31'h0, rdy}, 32'h1);
    @(posedge core_clk);
    sample_valid <= 1'b1;
    ch1 <= a;
    ch2 <= b;
    @(posedge core_clk);
    sample_valid <= 1'b0;
    ch1 <= ~a;
    ch2 <= ~b;
  endtask : push

  task automatic frame_chk(input logic [11:0] a, input logic [11:0] b);
    logic [15:0] w1;
    logic [15:0] w2;
    host.frame(w1, w2);
    check({16'h0000, w1}, {20'h00000, a});
    check({16'h0000, w2}, {20'h00000, b});
    check({30'h0, out_one, out_two}, 32'h0);
  endtask : frame_chk

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    check({29'h0, rdy, out_one, out_two}, 32'h0);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    // The release edge still resets; ready comes back one edge later
    #1 check({31'h0, rdy}, 32'h0);
    @(posedge core_clk);
    #1 check({31'h0, rdy}, 32'h1);
  endtask : t_reset

  // Intake is paced at one pair per microsecond
  task automatic t_pace();
    int n;
    push(12'hA5C, 12'h3C6);
    #1 check({31'h0, rdy}, 32'h0);
    n = 0;
    while (rdy !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      #1 n++;
    end
    // Ready is back in time for a take exactly one pace period later
    check(n, dasr_pkg::PACE_CYC - 1);
    frame_chk(12'hA5C, 12'h3C6);
  endtask : t_pace

  // Extreme codes, frames back to back, read in take order
  task automatic t_bounds();
    push(12'hFFF, 12'h000);
    push(12'h800, 12'h001);
    frame_chk(12'hFFF, 12'h000);
    frame_chk(12'h800, 12'h001);
  endtask : t_bounds

  task automatic t_underrun();
    int u;
    u = under_cnt;
    frame_chk(12'h000, 12'h000);
    check(under_cnt - u, 1);
  endtask : t_underrun

  // Queue holds 32 pairs and the holding stage one more: fill until it
  // refuses, then drain it with frames back to back
  task automatic t_fill_drain();
    logic [11:0] v;
    for (int i = 0; i < dasr_pkg::FIFO_DEPTH + 1; i++) begin
      v = 12'(i * 133 + 7);
      push(v, ~v);
    end
    repeat (150) @(posedge core_clk);
    #1 check({31'h0, rdy}, 32'h0);
    for (int i = 0; i < dasr_pkg::FIFO_DEPTH + 1; i++) begin
      v = 12'(i * 133 + 7);
      frame_chk(v, ~v);
    end
    t_underrun();
  endtask : t_fill_drain

  initial begin
    sys_rst = 1'b1;
    sample_valid = 1'b0;
    ch1 = 12'h000;
    ch2 = 12'h000;
    error_cnt = 0;
    checks = 0;
    under_cnt = 0;
    repeat (5) @(posedge core_clk);
    t_reset();
    t_pace();
    t_bounds();
    t_underrun();
    t_fill_drain();
    finish_test();
  end

  // Whole run is near 90 us; a hang is cut off well beyond that
  initial begin
    #400us;
    error_cnt++;
    finish_test();
  end
endmodule : dual_adc_serial_readout_test
`default_nettype wire
